// [hdl/icnt_cfg.svh]
// Contract
// - armed trigger B starts run, flags, interrupts
// - running modes 2/3: trigger B captures counter
// - trigger A is count source and pulse output
// - decode only on io page, bit 12, switches
// - base address any word ending 0 or 4
// - preset buffer sits at next even address
// - overflow vector from six switches, bits 8-3
// - trigger B vector is overflow vector plus four
// - slope select picks rising or falling edge
// - any byte write loads whole preset word
// - modes 2/3 preset reads return captured count
// - run write or armed trigger loads counter
// - single interval stops at overflow, clears run
// - overflow sets flag, interrupts when enabled
// - overflow and trigger A copied onto aux tabs
// - two-bit mode field selects four modes
// - three-bit rate field selects eight sources
// - repeat mode reloads on overflow, keeps running
// - mode 3 capture zeroes counter, mode 2 not
`ifndef ICNT_CFG_SVH
`define ICNT_CFG_SVH

// address decode
`define ICNT_IO_BIT 12
`define ICNT_OFS_CONTROL 1'b0
`define ICNT_OFS_PRESET 1'b1

// control word field positions
`define ICNT_B_RUN 0
`define ICNT_B_MODE_LO 1
`define ICNT_B_MODE_HI 2
`define ICNT_B_RATE_LO 3
`define ICNT_B_RATE_HI 5
`define ICNT_B_OVF_IE 6
`define ICNT_B_OVF_FLAG 7
`define ICNT_B_MAINT_A 8
`define ICNT_B_MAINT_B 9
`define ICNT_B_MAINT_OSC 10
`define ICNT_B_OSC_OFF 11
`define ICNT_B_OVERRUN 12
`define ICNT_B_ARM 13
`define ICNT_B_TRIGB_IE 14
`define ICNT_B_TRIGB_FLAG 15

// reset values
`define ICNT_RST_PRESET 16'h0000
`define ICNT_RST_VALUE 1'b0

// timing
`define ICNT_CLK_HZ 200000000
`define ICNT_BASE_HZ 10000000
`define ICNT_BASE_DIV (`ICNT_CLK_HZ / `ICNT_BASE_HZ)
`define ICNT_DECADE 10
`define ICNT_PULSE_NS 500
`define ICNT_PULSE_CYC ((`ICNT_PULSE_NS * (`ICNT_CLK_HZ / 1000000)) / 1000)
`define ICNT_VEC_STEP_B 4

`endif

// [hdl/icnt_pkg.sv]
package icnt_pkg;
    // operating modes
    typedef enum logic [1:0] {
        ICNT_MODE_SINGLE = 2'h0,
        ICNT_MODE_REPEAT = 2'h1,
        ICNT_MODE_EVENT = 2'h2,
        ICNT_MODE_EVENT_ZERO = 2'h3
    } icnt_mode_t;
    // count sources
    typedef enum logic [2:0] {
        ICNT_RATE_STOP = 3'h0,
        ICNT_RATE_1M = 3'h1,
        ICNT_RATE_100K = 3'h2,
        ICNT_RATE_10K = 3'h3,
        ICNT_RATE_1K = 3'h4,
        ICNT_RATE_100 = 3'h5,
        ICNT_RATE_TRIG_A = 3'h6,
        ICNT_RATE_LINE = 3'h7
    } icnt_rate_t;
    // bus slave states
    typedef enum logic [2:0] {
        ICNT_BUS_IDLE = 3'h1,
        ICNT_BUS_ACTIVE = 3'h2,
        ICNT_BUS_REPLY = 3'h4
    } icnt_bus_t;
endpackage : icnt_pkg

// [hdl/icnt_trig_if.sv]
`timescale 1ns/1ps
// raw trigger levels in, single-cycle events out; channel 0 A, 1 B, 2 line
interface icnt_trig_if;
    logic [2:0] rawIn;
    logic [2:0] slopeRise;
    logic [2:0] evt;
    modport detect (input rawIn, input slopeRise, output evt);
    modport user (output rawIn, output slopeRise, input evt);
endinterface : icnt_trig_if

// [hdl/icnt_trig_edge.sv]
`timescale 1ns/1ps
module icnt_trig_edge
    import icnt_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // trigger channels
    icnt_trig_if.detect trg
);
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] hist_r;
    logic [2:0] evt_r;

    assign trg.evt = evt_r;

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_ch
            // first stage feeds only the second stage
            always_ff @(posedge mclk) begin
                if (!reset_n) begin
                    // pipe follows the pin in reset, so an idle high pin fires no false edge
                    sync1_r[i] <= trg.rawIn[i];
                    sync2_r[i] <= trg.rawIn[i];
                    hist_r[i] <= trg.rawIn[i];
                    evt_r[i] <= 1'b0;
                end else begin
                    sync1_r[i] <= trg.rawIn[i];
                    sync2_r[i] <= sync1_r[i];
                    hist_r[i] <= sync2_r[i];
                    // slope chooses which transition fires
                    evt_r[i] <= trg.slopeRise[i] ? (sync2_r[i] & ~hist_r[i])
                                                 : (~sync2_r[i] & hist_r[i]);
                end
            end

            property p_evt_single;
                @(posedge mclk) disable iff (!reset_n)
                evt_r[i] |=> !evt_r[i];
            endproperty
            a_evt_single: assert property (p_evt_single)
                else $error("trigger event wider than one cycle");

            property p_slope;
                @(posedge mclk) disable iff (!reset_n)
                evt_r[i] |-> ($past(sync2_r[i]) == $past(trg.slopeRise[i]));
            endproperty
            a_slope: assert property (p_slope)
                else $error("trigger fired on wrong edge");
        end
    endgenerate
endmodule : icnt_trig_edge

// [hdl/icnt_core.sv]
`timescale 1ns/1ps
`include "icnt_cfg.svh"
module icnt_core
    import icnt_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int VEC_W = 6,
    parameter int ADR_SW_W = 10
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // multiplexed address/data bus
    input wire logic [DATA_W-1:0] adIn,
    output logic [DATA_W-1:0] adOut,
    output logic adOe_n,
    input wire logic busSync,
    input wire logic busDin,
    input wire logic busDout,
    input wire logic busWtbt,
    input wire logic ioPageSelect,
    output logic busRply,
    output logic irqReq,
    input wire logic irqAckIn,
    // board switches
    input wire logic [ADR_SW_W-1:0] addrSwitch,
    input wire logic [VEC_W-1:0] vectorSwitch,
    input wire logic slopeASel,
    input wire logic slopeBSel,
    // trigger and line inputs
    input wire logic extTriggerA,
    input wire logic extTriggerB,
    input wire logic lineFreqIn,
    // pulse outputs, active low
    output logic overflowPulseOut_n,
    output logic overflowPulseTab_n,
    output logic triggerAOut_n,
    output logic triggerATab_n
);
    localparam logic [4:0] BASE_DIV_M1 = 5'(`ICNT_BASE_DIV - 1);
    localparam logic [3:0] DECADE_M1 = 4'(`ICNT_DECADE - 1);
    localparam logic [6:0] PULSE_CYC = 7'(`ICNT_PULSE_CYC);
    localparam logic [DATA_W-1:0] ALL_ONES = '1;

    icnt_trig_if trg ();
    icnt_bus_t busState_r;
    logic syncD_r, sel_r, regSel_r, byteHi_r, drive_r;
    logic [DATA_W-1:0] adOut_r;
    logic countRun_r, trigBArm_r, trigBIrqEn_r, ovfIrqEn_r, oscOff_r;
    logic trigBFlag_r, ovfFlag_r, overrun_r;
    logic [1:0] mode_r;
    logic [2:0] rate_r;
    logic [DATA_W-1:0] counter_r, preset_r;
    logic [4:0] baseCnt_r;
    logic [3:0] decCnt_r [5];
    logic [5:0] stageTick;
    logic [1:0] reqLvlD_r, pend_r;
    logic [6:0] pulseCnt_r [2];
    logic [1:0] pulseOut_n_r;

    // synchronise and edge-detect triggers; line edge always rising
    assign trg.rawIn = {lineFreqIn, extTriggerB, extTriggerA};
    assign trg.slopeRise = {1'b1, slopeBSel, slopeASel};
    icnt_trig_edge u_edge (
        .mclk(mclk),
        .reset_n(reset_n),
        .trg(trg)
    );

    // bus strobes
    logic addrPhase, rdStb, wrStb, ackStb, wrCtl, wrLo, wrHi, wrPreset;
    logic [1:0] modeNow;
    logic [DATA_W-1:0] vecBase, ctlWord, rdData;
    assign addrPhase = (busState_r == ICNT_BUS_IDLE) && busSync && !syncD_r;
    assign rdStb = (busState_r == ICNT_BUS_ACTIVE) && sel_r && busDin;
    assign wrStb = (busState_r == ICNT_BUS_ACTIVE) && sel_r && busDout && !busDin;
    assign ackStb = (busState_r == ICNT_BUS_IDLE) && !busSync && irqAckIn && irqReq;
    assign wrCtl = wrStb && (regSel_r == `ICNT_OFS_CONTROL);
    assign wrLo = !busWtbt || !byteHi_r;
    assign wrHi = !busWtbt || byteHi_r;
    // preset is locked while capturing; byte lane ignored on purpose
    assign wrPreset = wrStb && (regSel_r == `ICNT_OFS_PRESET)
                      && !(countRun_r && mode_r[1]);
    assign modeNow = (wrCtl && wrLo) ? adIn[`ICNT_B_MODE_HI:`ICNT_B_MODE_LO] : mode_r;

    // counter events
    logic maintA, maintB, maintOsc, trigAEvt, trigBEvt, goRise, armStart, startEvt;
    logic rateTick, incEn, ovfEvt, capEvt, trigBSet;
    assign maintA = wrCtl && wrHi && adIn[`ICNT_B_MAINT_A];
    assign maintB = wrCtl && wrHi && adIn[`ICNT_B_MAINT_B];
    assign maintOsc = wrCtl && wrHi && adIn[`ICNT_B_MAINT_OSC];
    assign trigAEvt = trg.evt[0] || maintA;
    assign trigBEvt = trg.evt[1] || maintB;
    assign goRise = wrCtl && wrLo && adIn[`ICNT_B_RUN] && !countRun_r;
    assign armStart = trigBEvt && trigBArm_r;
    assign startEvt = goRise || armStart;
    assign incEn = countRun_r && rateTick;
    assign ovfEvt = incEn && (counter_r == ALL_ONES);
    assign capEvt = trigBEvt && countRun_r && mode_r[1] && !armStart;
    assign trigBSet = trigBEvt && (countRun_r || trigBArm_r);

    // bus slave: latch address on io page, reply to data strobes and acks
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            busState_r <= ICNT_BUS_IDLE;
            syncD_r <= 1'b0;
            sel_r <= 1'b0;
            regSel_r <= 1'b0;
            byteHi_r <= 1'b0;
            drive_r <= 1'b0;
        end else begin
            syncD_r <= busSync;
            case (busState_r)
                ICNT_BUS_IDLE: begin
                    drive_r <= 1'b0;
                    if (addrPhase) begin
                        // address switches hold bits 11-2; bit 1 picks the register
                        sel_r <= ioPageSelect && adIn[`ICNT_IO_BIT]
                                 && (adIn[11:2] == addrSwitch);
                        regSel_r <= adIn[1];
                        byteHi_r <= adIn[0];
                        busState_r <= ICNT_BUS_ACTIVE;
                    end else if (ackStb) begin
                        drive_r <= 1'b1;
                        busState_r <= ICNT_BUS_REPLY;
                    end
                end
                ICNT_BUS_ACTIVE: begin
                    if (!busSync) begin
                        sel_r <= 1'b0;
                        busState_r <= ICNT_BUS_IDLE;
                    end else if (rdStb || wrStb) begin
                        drive_r <= rdStb;
                        busState_r <= ICNT_BUS_REPLY;
                    end
                end
                ICNT_BUS_REPLY: begin
                    if (!busDin && !busDout && !irqAckIn) begin
                        drive_r <= 1'b0;
                        busState_r <= busSync ? ICNT_BUS_ACTIVE : ICNT_BUS_IDLE;
                    end
                end
                default: busState_r <= ICNT_BUS_IDLE;
            endcase
        end
    end

    // read data and vectors; overflow outranks trigger B
    assign vecBase = {{(DATA_W-VEC_W-3){1'b0}}, vectorSwitch, 3'h0};
    assign ctlWord = {trigBFlag_r, trigBIrqEn_r, trigBArm_r, overrun_r, oscOff_r, 3'h0,
                      ovfFlag_r, ovfIrqEn_r, rate_r, mode_r, countRun_r};
    assign rdData = (regSel_r == `ICNT_OFS_PRESET) ? preset_r : ctlWord;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            adOut_r <= '0;
        end else if (ackStb) begin
            // plus four lands on bit 2, which the switches never reach
            adOut_r <= pend_r[0] ? vecBase
                                 : (vecBase | DATA_W'(`ICNT_VEC_STEP_B));
        end else if (rdStb) begin
            adOut_r <= rdData;
        end
    end
    assign adOut = adOut_r;
    assign adOe_n = !drive_r;
    assign busRply = (busState_r == ICNT_BUS_REPLY);

    // software settings
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mode_r <= ICNT_MODE_SINGLE;
            rate_r <= ICNT_RATE_STOP;
            ovfIrqEn_r <= `ICNT_RST_VALUE;
            trigBIrqEn_r <= `ICNT_RST_VALUE;
            oscOff_r <= `ICNT_RST_VALUE;
        end else begin
            if (wrCtl && wrLo) begin
                mode_r <= adIn[`ICNT_B_MODE_HI:`ICNT_B_MODE_LO];
                rate_r <= adIn[`ICNT_B_RATE_HI:`ICNT_B_RATE_LO];
                ovfIrqEn_r <= adIn[`ICNT_B_OVF_IE];
            end
            if (wrCtl && wrHi) begin
                trigBIrqEn_r <= adIn[`ICNT_B_TRIGB_IE];
                oscOff_r <= adIn[`ICNT_B_OSC_OFF];
            end
        end
    end

    // time base: 10 MHz enable then five decade stages
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            baseCnt_r <= '0;
        end else begin
            baseCnt_r <= (baseCnt_r == BASE_DIV_M1) ? 5'h00 : 5'(baseCnt_r + 5'h01);
        end
    end
    // maintenance pulse steps the chain even with the oscillator off
    assign stageTick[0] = ((baseCnt_r == BASE_DIV_M1) && !oscOff_r) || maintOsc;
    genvar d;
    generate
        for (d = 0; d < 5; d++) begin : g_dec
            always_ff @(posedge mclk) begin
                if (!reset_n) begin
                    decCnt_r[d] <= '0;
                end else if (stageTick[d]) begin
                    decCnt_r[d] <= (decCnt_r[d] == DECADE_M1) ? 4'h0 : 4'(decCnt_r[d] + 4'h1);
                end
            end
            assign stageTick[d+1] = stageTick[d] && (decCnt_r[d] == DECADE_M1);
        end
    endgenerate

    // count source select
    always_comb begin
        case (icnt_rate_t'(rate_r))
            ICNT_RATE_STOP: rateTick = 1'b0;
            ICNT_RATE_1M: rateTick = stageTick[1];
            ICNT_RATE_100K: rateTick = stageTick[2];
            ICNT_RATE_10K: rateTick = stageTick[3];
            ICNT_RATE_1K: rateTick = stageTick[4];
            ICNT_RATE_100: rateTick = stageTick[5];
            ICNT_RATE_TRIG_A: rateTick = trigAEvt;
            ICNT_RATE_LINE: rateTick = trg.evt[2];
            default: rateTick = 1'b0;
        endcase
    end

    // run bit, arm bit and the counter itself
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            countRun_r <= `ICNT_RST_VALUE;
            trigBArm_r <= `ICNT_RST_VALUE;
            counter_r <= '0;
        end else begin
            if (startEvt) begin
                countRun_r <= 1'b1;
            end else if (ovfEvt && mode_r == ICNT_MODE_SINGLE) begin
                countRun_r <= 1'b0;
            end else if (wrCtl && wrLo) begin
                countRun_r <= adIn[`ICNT_B_RUN];
            end
            if (goRise || armStart) begin
                trigBArm_r <= 1'b0;
            end else if (wrCtl && wrHi) begin
                trigBArm_r <= adIn[`ICNT_B_ARM];
            end
            if (startEvt) begin
                counter_r <= modeNow[1] ? '0 : preset_r;
            end else if (capEvt && mode_r == ICNT_MODE_EVENT_ZERO) begin
                counter_r <= incEn ? DATA_W'(1) : '0;
            end else if (ovfEvt && mode_r == ICNT_MODE_REPEAT) begin
                counter_r <= preset_r;
            end else if (incEn) begin
                counter_r <= counter_r + DATA_W'(1);
            end
        end
    end

    // preset buffer: program load or capture
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            preset_r <= `ICNT_RST_PRESET;
        end else if (capEvt) begin
            preset_r <= counter_r;
        end else if (wrPreset) begin
            preset_r <= adIn;
        end
    end

    // status flags; hardware set beats software clear
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            trigBFlag_r <= `ICNT_RST_VALUE;
            ovfFlag_r <= `ICNT_RST_VALUE;
            overrun_r <= `ICNT_RST_VALUE;
        end else begin
            if (trigBSet) begin
                trigBFlag_r <= 1'b1;
            end else if ((goRise && !trigBArm_r)
                         || (wrCtl && wrHi && !adIn[`ICNT_B_TRIGB_FLAG])) begin
                trigBFlag_r <= 1'b0;
            end
            if (ovfEvt) begin
                ovfFlag_r <= 1'b1;
            end else if (goRise || (wrCtl && wrLo && !adIn[`ICNT_B_OVF_FLAG])) begin
                ovfFlag_r <= 1'b0;
            end
            if ((ovfEvt && ovfFlag_r) || (trigBSet && trigBFlag_r)) begin
                overrun_r <= 1'b1;
            end else if (goRise) begin
                overrun_r <= 1'b0;
            end else if (wrCtl && wrHi) begin
                overrun_r <= adIn[`ICNT_B_OVERRUN];
            end
        end
    end

    // interrupt requests: armed on a rising request level, dropped on ack
    logic [1:0] reqLvl;
    assign reqLvl = {trigBFlag_r && trigBIrqEn_r, ovfFlag_r && ovfIrqEn_r};
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            reqLvlD_r <= 2'h0;
            pend_r <= 2'h0;
        end else begin
            reqLvlD_r <= reqLvl;
            pend_r[0] <= reqLvl[0] && ((reqLvl[0] && !reqLvlD_r[0])
                         || (pend_r[0] && !ackStb));
            pend_r[1] <= reqLvl[1] && ((reqLvl[1] && !reqLvlD_r[1])
                         || (pend_r[1] && !(ackStb && !pend_r[0])));
        end
    end
    assign irqReq = |pend_r;

    // stretched output pulses, 0 overflow and 1 trigger A
    logic [1:0] pulseFire;
    assign pulseFire = {trigAEvt, ovfEvt};
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_pulse
            always_ff @(posedge mclk) begin
                if (!reset_n) begin
                    pulseCnt_r[p] <= '0;
                    pulseOut_n_r[p] <= 1'b1;
                end else begin
                    if (pulseFire[p]) begin
                        pulseCnt_r[p] <= PULSE_CYC;
                    end else if (pulseCnt_r[p] != 7'h00) begin
                        pulseCnt_r[p] <= 7'(pulseCnt_r[p] - 7'h01);
                    end
                    pulseOut_n_r[p] <= !(pulseFire[p] || (pulseCnt_r[p] > 7'h01));
                end
            end
        end
    endgenerate
    // tabs wired in parallel with the connector pins
    assign overflowPulseOut_n = pulseOut_n_r[0];
    assign overflowPulseTab_n = pulseOut_n_r[0];
    assign triggerAOut_n = pulseOut_n_r[1];
    assign triggerATab_n = pulseOut_n_r[1];

    property p_cap_copy;
        @(posedge mclk) disable iff (!reset_n)
        capEvt |=> (preset_r == $past(counter_r));
    endproperty
    a_cap_copy: assert property (p_cap_copy)
        else $error("capture did not copy counter");

    property p_arm_start;
        @(posedge mclk) disable iff (!reset_n)
        armStart |=> (countRun_r && trigBFlag_r && !trigBArm_r);
    endproperty
    a_arm_start: assert property (p_arm_start)
        else $error("armed trigger did not start");

    property p_no_sel_no_reply;
        @(posedge mclk) disable iff (!reset_n)
        (busState_r == ICNT_BUS_ACTIVE && !sel_r) |=> !busRply;
    endproperty
    a_no_sel_no_reply: assert property (p_no_sel_no_reply)
        else $error("reply without address match");

    property p_vec_b;
        @(posedge mclk) disable iff (!reset_n)
        (ackStb && !pend_r[0]) |=> (adOut_r == $past(vecBase) + DATA_W'(4)) && !adOe_n;
    endproperty
    a_vec_b: assert property (p_vec_b)
        else $error("trigger B vector wrong");

    property p_single_stop;
        @(posedge mclk) disable iff (!reset_n)
        (ovfEvt && mode_r == ICNT_MODE_SINGLE) |=> (!countRun_r && ovfFlag_r);
    endproperty
    a_single_stop: assert property (p_single_stop)
        else $error("single interval did not stop");

    property p_repeat;
        @(posedge mclk) disable iff (!reset_n)
        (ovfEvt && mode_r == ICNT_MODE_REPEAT) |=> (countRun_r
            && counter_r == $past(preset_r));
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("repeat mode did not reload");

    property p_zero_base;
        @(posedge mclk) disable iff (!reset_n)
        (capEvt && mode_r == ICNT_MODE_EVENT_ZERO) |=> (counter_r <= DATA_W'(1));
    endproperty
    a_zero_base: assert property (p_zero_base)
        else $error("mode 3 capture did not zero counter");

    property p_go_load;
        @(posedge mclk) disable iff (!reset_n)
        (goRise && !modeNow[1]) |=> (counter_r == $past(preset_r));
    endproperty
    a_go_load: assert property (p_go_load)
        else $error("run write did not load preset");

    property p_ovf_pulse;
        @(posedge mclk) disable iff (!reset_n)
        ovfEvt |=> (!overflowPulseOut_n && !overflowPulseTab_n) [*8];
    endproperty
    a_ovf_pulse: assert property (p_ovf_pulse)
        else $error("overflow pulse too short");

    property p_count_step;
        @(posedge mclk) disable iff (!reset_n)
        (incEn && !ovfEvt && !startEvt && !capEvt) |=>
            (counter_r == $past(counter_r) + DATA_W'(1));
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step on source tick");
endmodule : icnt_core

// [dv/icnt_host_model.sv]
`timescale 1ns/1ps
module icnt_host_model (
    // clock
    input wire logic mclk,
    // host drive
    output logic [15:0] adIn,
    output logic busSync,
    output logic busDin,
    output logic busDout,
    output logic busWtbt,
    output logic ioPageSelect,
    output logic irqAckIn,
    // device answer
    input wire logic [15:0] adOut,
    input wire logic busRply
);
    initial begin
        {busSync, busDin, busDout, busWtbt, ioPageSelect, irqAckIn} = 6'h00;
        adIn = 16'h5AA5;
    end
    // bounded so a missing reply cannot hang the host
    task automatic waitRply(input logic lv, output logic ok);
        for (int n = 0; n < 40 && busRply !== lv; n++) @(posedge mclk);
        ok = (busRply === lv);
    endtask : waitRply
    // strobe held until reply; released lines show the inverse pattern
    task automatic xfer(input logic [15:0] a, w, input logic rd, bt,
                        output logic [15:0] r, output logic ok);
        logic d;
        @(posedge mclk);
        adIn <= a;
        busSync <= 1'b1;
        ioPageSelect <= 1'b1;
        @(posedge mclk);
        adIn <= rd ? ~a : w;
        ioPageSelect <= 1'b0;
        busDin <= rd;
        busDout <= !rd;
        busWtbt <= bt;
        waitRply(1'b1, ok);
        r = adOut;
        {busDin, busDout, busWtbt} <= 3'h0;
        waitRply(1'b0, d);
        busSync <= 1'b0;
        adIn <= ~adIn;
        @(posedge mclk);
    endtask : xfer
    // interrupt acknowledge, vector taken with the reply
    task automatic ack(output logic [15:0] v);
        logic d;
        @(posedge mclk);
        irqAckIn <= 1'b1;
        waitRply(1'b1, d);
        v = adOut;
        irqAckIn <= 1'b0;
        waitRply(1'b0, d);
    endtask : ack
endmodule : icnt_host_model

// [dv/interval_counter_triggers_tb.sv]
`timescale 1ns/1ps
module interval_counter_triggers_tb;
    typedef struct {logic [15:0] a, w, e; logic bt;} icnt_row_t;
    logic mclk, reset_n, extTriggerA, extTriggerB, slopeASel, irqReq, busRply, ok;
    logic [15:0] adIn, adOut, r;
    logic busSync, busDin, busDout, busWtbt, ioPageSelect, irqAckIn, adOe_n;
    logic ovfOut_n, ovfTab_n, trgOut_n, trgTab_n;
    int nMismatch = 0;
    int nCompared = 0;
    // preset word, preset word again (wr ignores the bt flag), control with write-only bits, control clear
    icnt_row_t rows[4] = '{'{16'hF112, 16'h1234, 16'h1234, 1'b0},
        '{16'hF112, 16'hABCD, 16'hABCD, 1'b1}, '{16'hF110, 16'h0736, 16'h0036, 1'b0},
        '{16'hF110, 16'h0000, 16'h0000, 1'b0}};
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // base 170420 octal, vector 440 octal
    icnt_core i_dut (.mclk(mclk), .reset_n(reset_n), .adIn(adIn), .adOut(adOut),
        .adOe_n(adOe_n), .busSync(busSync), .busDin(busDin), .busDout(busDout),
        .busWtbt(busWtbt), .ioPageSelect(ioPageSelect), .busRply(busRply),
        .irqReq(irqReq), .irqAckIn(irqAckIn), .addrSwitch(10'h044), .vectorSwitch(6'h24),
        .slopeASel(slopeASel), .slopeBSel(1'b1), .extTriggerA(extTriggerA),
        .extTriggerB(extTriggerB), .lineFreqIn(1'b0), .overflowPulseOut_n(ovfOut_n),
        .overflowPulseTab_n(ovfTab_n), .triggerAOut_n(trgOut_n), .triggerATab_n(trgTab_n));
    icnt_host_model i_host (.mclk(mclk), .adIn(adIn), .busSync(busSync), .busDin(busDin),
        .busDout(busDout), .busWtbt(busWtbt), .ioPageSelect(ioPageSelect),
        .irqAckIn(irqAckIn), .adOut(adOut), .busRply(busRply));
    task automatic check(input string nm, input logic [15:0] seen, exp);
        nCompared++;
        if (seen !== exp) begin
            nMismatch++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("compared %0d mismatched %0d", nCompared, nMismatch);
        if (nMismatch == 0 && nCompared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    task automatic wr(input logic [15:0] a, w);
        logic [15:0] d;
        i_host.xfer(a, w, 1'b0, 1'b0, d, ok);
    endtask : wr
    task automatic rdChk(input logic [15:0] a, e, input string nm);
        logic [15:0] d;
        i_host.xfer(a, 16'h0000, 1'b1, 1'b0, d, ok);
        check(nm, d, e);
    endtask : rdChk
    task automatic waitIrq();
        for (int n = 0; n < 2000 && irqReq !== 1'b1; n++) @(posedge mclk);
        check("irq", {15'h0000, irqReq}, 16'h0001);
    endtask : waitIrq
    // watchdog well beyond the expected run of under two thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        nMismatch++;
        results();
    end
    initial begin
        {reset_n, extTriggerA, extTriggerB, slopeASel} = 4'b0100;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rdChk(rows[i].a, rows[i].e, "readback");
        end
        i_host.xfer(16'hE110, 16'h0000, 1'b1, 1'b0, r, ok);
        check("stray reply", {15'h0000, ok}, 16'h0000);
        // two ticks of 1 MHz, preset written before control
        wr(16'hF112, 16'hFFFE);
        wr(16'hF110, 16'h0049);
        waitIrq();
        repeat (3) @(posedge mclk);
        check("ovf pulses", {14'h0000, ovfOut_n, ovfTab_n}, 16'h0000);
        i_host.ack(r);
        check("ovf vector", r, 16'h0120);
        rdChk(16'hF110, 16'h00C8, "single stop");
        // clear flag and arm; trigger B starts the run
        wr(16'hF110, 16'h6000);
        extTriggerB <= 1'b1;
        waitIrq();
        i_host.ack(r);
        check("trig b vector", r, 16'h0124);
        rdChk(16'hF110, 16'hC001, "armed start");
        // event timing: capture near three ticks, preset then locked
        wr(16'hF110, 16'h0000);
        extTriggerB <= 1'b0;
        wr(16'hF110, 16'h000D);
        repeat (650) @(posedge mclk);
        extTriggerB <= 1'b1;
        repeat (8) @(posedge mclk);
        i_host.xfer(16'hF112, 16'h0000, 1'b1, 1'b0, r, ok);
        check("capture", {15'h0000, r >= 16'h0003 && r <= 16'h0004}, 16'h0001);
        wr(16'hF112, 16'h5555);
        rdChk(16'hF112, r, "locked preset");
        // mode 3: each capture zeroes the counter, so a quick second capture is small
        wr(16'hF110, 16'h000F);
        extTriggerB <= 1'b0;
        repeat (8) @(posedge mclk);
        extTriggerB <= 1'b1;
        repeat (8) @(posedge mclk);
        extTriggerB <= 1'b0;
        repeat (8) @(posedge mclk);
        extTriggerB <= 1'b1;
        repeat (8) @(posedge mclk);
        i_host.xfer(16'hF112, 16'h0000, 1'b1, 1'b0, r, ok);
        check("zero base", {15'h0000, r <= 16'h0001}, 16'h0001);
        // repeat mode: overflow reloads from preset and the run bit stays set
        wr(16'hF110, 16'h0000);
        wr(16'hF112, 16'hFFFF);
        wr(16'hF110, 16'h004B);
        waitIrq();
        i_host.ack(r);
        check("repeat vector", r, 16'h0120);
        rdChk(16'hF110, 16'h00CB, "repeat run");
        // falling slope on trigger A
        extTriggerA <= 1'b0;
        repeat (6) @(posedge mclk);
        check("trig a out", {14'h0000, trgOut_n, trgTab_n}, 16'h0000);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        check("oe in reset", {15'h0000, adOe_n}, 16'h0001);
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        rdChk(16'hF112, 16'h0000, "preset reset");
        results();
    end
endmodule : interval_counter_triggers_tb
